// ### snbpc_defines.vh
`ifndef SNBPC_DEFINES_VH
`define SNBPC_DEFINES_VH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SNBPC_CLK_HZ 200000000
`define SNBPC_RUN_HZ 5
`define SNBPC_RUN_HALF_CYC (`SNBPC_CLK_HZ / (2 * `SNBPC_RUN_HZ))
`define SNBPC_ACT_PERIOD_MS 60
`define SNBPC_ACT_LOW_MS 10
`define SNBPC_ACT_PERIOD_CYC ((`SNBPC_CLK_HZ / 1000) * `SNBPC_ACT_PERIOD_MS)
`define SNBPC_ACT_LOW_CYC ((`SNBPC_CLK_HZ / 1000) * `SNBPC_ACT_LOW_MS)
`define SNBPC_RESTORE_S 5
`define SNBPC_RESTORE_CYC (`SNBPC_CLK_HZ * `SNBPC_RESTORE_S)
`define SNBPC_INIT_CYC 1000
// ----------------------------------------
// factory defaults, mode codes and client limit
// ----------------------------------------
`define SNBPC_DEF_LOCAL_PORT 16'h22B7
`define SNBPC_DEF_WEB_PORT 16'h0050
`define SNBPC_DEF_BAUD 24'h01C200
`define SNBPC_DEF_DATA_BITS 4'h8
`define SNBPC_DEF_STOP_BITS 2'h1
`define SNBPC_PARITY_NONE 3'h0
`define SNBPC_MODE_TCP_SERVER 2'h0
`define SNBPC_MODE_TCP_CLIENT 2'h1
`define SNBPC_MODE_UDP_SERVER 2'h2
`define SNBPC_MODE_UDP_CLIENT 2'h3
`define SNBPC_DEF_DNS 32'h72727272
`define SNBPC_MAX_CLIENTS 3'h6
`endif

// ### snbpc_act_ind.v
`timescale 1ns/1ps
`include "snbpc_defines.vh"
module snbpc_act_ind #(
    parameter [31:0] PERIOD_CYC = `SNBPC_ACT_PERIOD_CYC,
    parameter [31:0] LOW_CYC = `SNBPC_ACT_LOW_CYC
) (
    input wire clk_sys,
    input wire rst,
    input wire activity,
    output reg indicator_n
);
    // ----------------------------------------
    // period counter, restarts only at period end
    // ----------------------------------------
    reg busy_r;
    reg [31:0] cnt_r;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            cnt_r <= 32'h00000000;
            indicator_n <= 1'b1;
        end else begin
            if (!busy_r) begin
                cnt_r <= 32'h00000000;
                indicator_n <= 1'b1;
                if (activity) begin
                    busy_r <= 1'b1;
                    indicator_n <= 1'b0;
                end
            end else if (cnt_r == PERIOD_CYC - 32'h00000001) begin
                // back-to-back period if data still flowing, else rest high
                cnt_r <= 32'h00000000;
                busy_r <= activity;
                indicator_n <= ~activity;
            end else begin
                cnt_r <= cnt_r + 32'h00000001;
                indicator_n <= (cnt_r + 32'h00000001 >= LOW_CYC);
            end
        end
    end
endmodule

// ### snbpc_pin_ctrl.v
`timescale 1ns/1ps
`include "snbpc_defines.vh"
module snbpc_pin_ctrl #(
    parameter [31:0] RESTORE_CYC = `SNBPC_RESTORE_CYC,
    parameter [31:0] ACT_PERIOD_CYC = `SNBPC_ACT_PERIOD_CYC,
    parameter [31:0] ACT_LOW_CYC = `SNBPC_ACT_LOW_CYC,
    parameter [31:0] RUN_HALF_CYC = `SNBPC_RUN_HALF_CYC,
    parameter [31:0] INIT_CYC = `SNBPC_INIT_CYC
) (
    input wire clk_sys,
    input wire rst,
    input wire ext_reset_n,
    input wire factory_restore_n,
    input wire main_serial_tx_busy,
    input wire main_serial_in,
    input wire tcp_connected,
    input wire [2:0] client_count,
    input wire client_connect_req,
    input wire serial_block_valid,
    input wire [15:0] listen_port_match,
    input wire dhcp_enable,
    input wire [31:0] dhcp_dns,
    input wire cfg_we,
    input wire [1:0] cfg_mode,
    input wire [15:0] cfg_local_port,
    input wire [15:0] cfg_web_port,
    input wire [23:0] cfg_baud,
    input wire [31:0] cfg_dns,
    input wire cfg_register_pkt,
    input wire upgrade_select,
    output reg rs485_drive_en,
    output reg network_link_indicator,
    output reg run_indicator,
    output wire send_activity_indicator,
    output wire receive_activity_indicator,
    output reg soft_restart,
    output reg factory_restored,
    output reg [1:0] net_mode,
    output reg [15:0] local_port,
    output reg [15:0] web_port,
    output reg [23:0] serial_baud,
    output reg [3:0] serial_data_bits,
    output reg [2:0] serial_parity,
    output reg [1:0] serial_stop_bits,
    output reg register_pkt_en,
    output reg [31:0] dns_server,
    output reg dns_read_only,
    output reg accept_client,
    output reg [5:0] client_forward_mask,
    output reg main_port_upgrade,
    output reg debug_port_only
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [1:0] rst_sync_r;
    reg [1:0] fr_sync_r;
    reg [1:0] rx_sync_r;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rst_sync_r <= 2'h3;
            fr_sync_r <= 2'h3;
            rx_sync_r <= 2'h3;
        end else begin
            rst_sync_r <= {rst_sync_r[0], ext_reset_n};
            fr_sync_r <= {fr_sync_r[0], factory_restore_n};
            rx_sync_r <= {rx_sync_r[0], main_serial_in};
        end
    end
    wire ext_rst_low = ~rst_sync_r[1];
    wire fr_low = ~fr_sync_r[1];
    // ----------------------------------------
    // reset hold timer
    // ----------------------------------------
    // restore fires once per press; restart follows release so the hold is measurable
    reg [31:0] hold_cnt_r;
    reg restore_armed_r;
    reg ext_rst_prev_r;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_cnt_r <= 32'h00000000;
            restore_armed_r <= 1'b0;
            ext_rst_prev_r <= 1'b0;
            soft_restart <= 1'b0;
        end else begin
            ext_rst_prev_r <= ext_rst_low;
            soft_restart <= ext_rst_prev_r & ~ext_rst_low;
            if (ext_rst_low) begin
                if (hold_cnt_r != RESTORE_CYC) begin
                    hold_cnt_r <= hold_cnt_r + 32'h00000001;
                end
            end else begin
                hold_cnt_r <= 32'h00000000;
            end
            restore_armed_r <= ext_rst_low && (hold_cnt_r == RESTORE_CYC - 32'h00000001);
        end
    end
    wire do_restore = restore_armed_r | (fr_low & ~ext_rst_low);
    // ----------------------------------------
    // configuration store
    // ----------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            net_mode <= `SNBPC_MODE_TCP_SERVER;
            local_port <= `SNBPC_DEF_LOCAL_PORT;
            web_port <= `SNBPC_DEF_WEB_PORT;
            serial_baud <= `SNBPC_DEF_BAUD;
            serial_data_bits <= `SNBPC_DEF_DATA_BITS;
            serial_parity <= `SNBPC_PARITY_NONE;
            serial_stop_bits <= `SNBPC_DEF_STOP_BITS;
            register_pkt_en <= 1'b0;
            dns_server <= `SNBPC_DEF_DNS;
            factory_restored <= 1'b0;
        end else begin
            factory_restored <= do_restore;
            if (do_restore) begin
                net_mode <= `SNBPC_MODE_TCP_SERVER;
                local_port <= `SNBPC_DEF_LOCAL_PORT;
                web_port <= `SNBPC_DEF_WEB_PORT;
                serial_baud <= `SNBPC_DEF_BAUD;
                serial_data_bits <= `SNBPC_DEF_DATA_BITS;
                serial_parity <= `SNBPC_PARITY_NONE;
                serial_stop_bits <= `SNBPC_DEF_STOP_BITS;
                register_pkt_en <= 1'b0;
                dns_server <= `SNBPC_DEF_DNS;
            end else begin
                if (cfg_we) begin
                    net_mode <= cfg_mode;
                    local_port <= cfg_local_port;
                    web_port <= cfg_web_port;
                    serial_baud <= cfg_baud;
                    register_pkt_en <= cfg_register_pkt;
                end
                if (dhcp_enable) begin
                    dns_server <= dhcp_dns;
                end else if (cfg_we) begin
                    dns_server <= cfg_dns;
                end
            end
        end
    end
    // ----------------------------------------
    // init and run indicator
    // ----------------------------------------
    reg [31:0] init_cnt_r;
    reg init_done_r;
    reg [31:0] run_cnt_r;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            init_cnt_r <= 32'h00000000;
            init_done_r <= 1'b0;
            run_cnt_r <= 32'h00000000;
            run_indicator <= 1'b1;
        end else begin
            if (!init_done_r) begin
                init_cnt_r <= init_cnt_r + 32'h00000001;
                init_done_r <= (init_cnt_r == INIT_CYC - 32'h00000001);
            end else if (run_cnt_r == RUN_HALF_CYC - 32'h00000001) begin
                run_cnt_r <= 32'h00000000;
                run_indicator <= ~run_indicator;
            end else begin
                run_cnt_r <= run_cnt_r + 32'h00000001;
            end
        end
    end
    // ----------------------------------------
    // link, driver enable, server fan-out
    // ----------------------------------------
    wire udp_mode = net_mode[1];
    wire server_mode = (net_mode == `SNBPC_MODE_TCP_SERVER);
    wire [2:0] max_clients = `SNBPC_MAX_CLIENTS;
    // ----------------------------------------
    // per-client forward enables
    // ----------------------------------------
    // slots fill from zero, so slot i is live while i is below the count
    wire [2:0] live_clients = (client_count > max_clients) ? max_clients : client_count;
    wire block_fwd = server_mode & serial_block_valid;
    wire [5:0] client_forward_mask_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < `SNBPC_MAX_CLIENTS; gi = gi + 1) begin : g_client
            assign client_forward_mask_nxt[gi] = block_fwd & (live_clients > gi);
        end
    endgenerate
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rs485_drive_en <= 1'b0;
            network_link_indicator <= 1'b1;
            accept_client <= 1'b0;
            client_forward_mask <= 6'h00;
            main_port_upgrade <= 1'b0;
            debug_port_only <= 1'b1;
            dns_read_only <= 1'b0;
        end else begin
            rs485_drive_en <= main_serial_tx_busy;
            if (udp_mode) begin
                network_link_indicator <= 1'b0;
            end else begin
                network_link_indicator <= ~tcp_connected;
            end
            accept_client <= server_mode && client_connect_req && (listen_port_match == local_port)
                && (client_count < max_clients);
            client_forward_mask <= client_forward_mask_nxt;
            // dhcp owns the address, so the page must not offer it for edit
            dns_read_only <= dhcp_enable;
            main_port_upgrade <= upgrade_select;
            debug_port_only <= 1'b1;
        end
    end
    // ----------------------------------------
    // activity indicators
    // ----------------------------------------
    wire rx_active = ~rx_sync_r[1];
    snbpc_act_ind #(
        .PERIOD_CYC(ACT_PERIOD_CYC),
        .LOW_CYC(ACT_LOW_CYC)
    ) u_send_ind (
        .clk_sys(clk_sys),
        .rst(rst),
        .activity(main_serial_tx_busy),
        .indicator_n(send_activity_indicator)
    );
    snbpc_act_ind #(
        .PERIOD_CYC(ACT_PERIOD_CYC),
        .LOW_CYC(ACT_LOW_CYC)
    ) u_recv_ind (
        .clk_sys(clk_sys),
        .rst(rst),
        .activity(rx_active),
        .indicator_n(receive_activity_indicator)
    );
endmodule

// ### snbpc_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks
// ----------------------------------------
module snbpc_chk (
    input wire clk_sys,
    input wire rst,
    input wire ext_reset_n,
    input wire main_serial_tx_busy,
    input wire tcp_connected,
    input wire [2:0] client_count,
    input wire serial_block_valid,
    input wire rs485_drive_en,
    input wire network_link_indicator,
    input wire run_indicator,
    input wire send_activity_indicator,
    input wire receive_activity_indicator,
    input wire soft_restart,
    input wire factory_restored,
    input wire [1:0] net_mode,
    input wire [15:0] local_port,
    input wire [23:0] serial_baud,
    input wire [5:0] client_forward_mask
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    rs485_on_a: assert property (main_serial_tx_busy |=> rs485_drive_en) else $error("enable low");
    link_udp_a: assert property (net_mode[1] |=> !network_link_indicator) else $error("udp link");
    link_tcp_a: assert property (!net_mode[1] |=> network_link_indicator == !$past(tcp_connected))
        else $error("tcp link");
    // half period fixed at 8, the value the bench sets
    run_half_a: assert property ($changed(run_indicator) |=> $stable(run_indicator)[*7] ##1
        $changed(run_indicator)) else $error("run period");
    send_low_a: assert property ($fell(send_activity_indicator) |=> !send_activity_indicator[*8]
        ##1 !send_activity_indicator ##1 send_activity_indicator) else $error("send low time");
    recv_low_a: assert property ($fell(receive_activity_indicator) |=> !receive_activity_indicator[*8]
        ##1 !receive_activity_indicator ##1 receive_activity_indicator) else $error("recv low time");
    send_cause_a: assert property ($fell(send_activity_indicator) |-> $past(main_serial_tx_busy))
        else $error("send without data");
    restore_def_a: assert property (factory_restored |-> local_port == 16'h22B7 && net_mode == 2'h0
        && serial_baud == 24'h01C200) else $error("defaults");
    restart_a: assert property ($rose(ext_reset_n) |-> ##[1:4] soft_restart) else $error("no restart");
    fanout_a: assert property (serial_block_valid && net_mode == 2'h0 |=>
        client_forward_mask == (6'h01 << $past(client_count)) - 6'h01) else $error("fanout");
    cover property ($fell(send_activity_indicator));
    cover property (factory_restored);
    cover property (soft_restart);
endmodule
bind snbpc_pin_ctrl snbpc_chk chk (.*);

// ### snbpc_host_uart.sv
`timescale 1ns/1ps
// ----------------------------------------
// host serial sender, idle at mark level
// ----------------------------------------
module snbpc_host_uart #(parameter BIT_CYC = 4) (
    input wire clk_sys,
    input wire go,
    input wire [7:0] byte_in,
    output reg line
);
    reg [9:0] sh_r = 10'h3FF;
    reg [7:0] cnt_r = 8'h00;
    reg [3:0] left_r = 4'h0;
    initial line = 1'b1;
    always @(posedge clk_sys) begin
        if (go && left_r == 4'h0) begin
            sh_r <= {1'b1, byte_in, 1'b0};
            left_r <= 4'hA;
            cnt_r <= 8'h00;
        end else if (left_r != 4'h0) begin
            if (cnt_r == 8'h00) begin
                line <= sh_r[0];
                sh_r <= {1'b1, sh_r[9:1]};
                left_r <= left_r - 4'h1;
            end
            cnt_r <= (cnt_r == BIT_CYC - 1) ? 8'h00 : cnt_r + 8'h01;
        end
    end
endmodule

// ### snbpc_pin_ctrl_tb.sv
`timescale 1ns/1ps
`include "snbpc_defines.vh"
module snbpc_pin_ctrl_tb;
    reg clk_sys = 1'b0, rst = 1'b1, ext_reset_n = 1'b1, factory_restore_n = 1'b1, main_serial_tx_busy = 1'b0;
    reg tcp_connected = 1'b0, client_connect_req = 1'b0, serial_block_valid = 1'b0, dhcp_enable = 1'b0;
    reg cfg_we = 1'b0, cfg_register_pkt = 1'b0, upgrade_select = 1'b0, go = 1'b0;
    reg [2:0] client_count = 3'h0;
    reg [1:0] cfg_mode = 2'h0;
    reg [15:0] listen_port_match = 16'h0000, cfg_local_port = 16'h0000, cfg_web_port = 16'h0000;
    reg [23:0] cfg_baud = 24'h000000;
    reg [31:0] cfg_dns = 32'h00000000, dhcp_dns = 32'h00000000;
    wire main_serial_in, rs485_drive_en, network_link_indicator, run_indicator, send_activity_indicator;
    wire receive_activity_indicator, soft_restart, factory_restored, register_pkt_en, dns_read_only;
    wire accept_client, main_port_upgrade, debug_port_only;
    wire [1:0] net_mode, serial_stop_bits;
    wire [15:0] local_port, web_port;
    wire [23:0] serial_baud;
    wire [3:0] serial_data_bits;
    wire [2:0] serial_parity;
    wire [31:0] dns_server;
    wire [5:0] client_forward_mask;
    int bad_count = 0, total_checks = 0, n;
    snbpc_pin_ctrl #(.RESTORE_CYC(32'h64), .ACT_PERIOD_CYC(32'h3C), .ACT_LOW_CYC(32'h0A),
        .RUN_HALF_CYC(32'h08), .INIT_CYC(32'h04)) uut (.*);
    snbpc_host_uart #(.BIT_CYC(4)) host (.clk_sys(clk_sys), .go(go), .byte_in(8'h00), .line(main_serial_in));
    initial forever #2.5 clk_sys = ~clk_sys;
    task tick(input int k); repeat (k) @(posedge clk_sys); endtask
    task chk(input [31:0] got, input [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cfg(input [1:0] m, input [15:0] p);
        tick(1); cfg_we <= 1'b1; cfg_mode <= m; cfg_local_port <= p; cfg_dns <= 32'h01020304;
        cfg_web_port <= ~p;
        cfg_baud <= {8'h00, p};
        cfg_register_pkt <= p[0];
        tick(1); cfg_we <= 1'b0;
        tick(2);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin #20000; bad_count++; report_and_stop; end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task test_defaults;
        tick(2);
        rst <= 1'b0;
        tick(3);
        #1 chk({local_port, web_port}, {`SNBPC_DEF_LOCAL_PORT, `SNBPC_DEF_WEB_PORT});
        chk(dns_server, `SNBPC_DEF_DNS);
        chk(dns_read_only, 32'h0);
        chk({serial_data_bits, serial_parity, serial_stop_bits, debug_port_only}, 32'h203);
        $display("test defaults done");
    endtask
    task test_send;
        tick(1);
        main_serial_tx_busy <= 1'b1;
        tick(1);
        #1 chk({rs485_drive_en, send_activity_indicator}, 32'h2);
        tick(9);
        #1 chk(send_activity_indicator, 32'h0);
        tick(1);
        #1 chk(send_activity_indicator, 32'h1);
        tick(50);
        main_serial_tx_busy <= 1'b0;
        #1 chk(send_activity_indicator, 32'h0);
        tick(70);
        #1 chk({rs485_drive_en, send_activity_indicator}, 32'h1);
        $display("test send done");
    endtask
    task test_run;
        n = 0;
        while (run_indicator === 1'b1 && n < 50) begin
            tick(1);
            #1 n++;
        end
        n = 0;
        while (run_indicator === 1'b0 && n < 50) begin
            tick(1);
            #1 n++;
        end
        chk(n, 32'h8);
        $display("test run done");
    endtask
    task test_receive;
        tick(1);
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        n = 0;
        while (receive_activity_indicator !== 1'b0 && n < 20) begin
            tick(1);
            #1 n++;
        end
        chk(receive_activity_indicator, 32'h0);
        tick(150);
        #1 chk(receive_activity_indicator, 32'h1);
        $display("test receive done");
    endtask
    task test_link;
        cfg(2'h2, 16'h1234);
        #1 chk({network_link_indicator, net_mode}, 32'h2);
        chk(dns_server, 32'h01020304);
        cfg(2'h3, 16'h1234);
        #1 chk({network_link_indicator, net_mode}, 32'h3);
        cfg(2'h1, 16'h1234);
        #1 chk(network_link_indicator, 32'h1);
        tick(1);
        tcp_connected <= 1'b1;
        tick(2);
        #1 chk(network_link_indicator, 32'h0);
        $display("test link done");
    endtask
    task test_restore;
        tick(1);
        ext_reset_n <= 1'b0;
        tick(20);
        ext_reset_n <= 1'b1;
        tick(3);
        #1 chk(local_port, 32'h1234);
        tick(1);
        ext_reset_n <= 1'b0;
        tick(110);
        #1 chk(local_port, `SNBPC_DEF_LOCAL_PORT);
        chk(net_mode, `SNBPC_MODE_TCP_SERVER);
        tick(1);
        ext_reset_n <= 1'b1;
        n = 0;
        while (soft_restart !== 1'b1 && n < 6) begin
            tick(1);
            #1 n++;
        end
        chk(soft_restart, 32'h1);
        cfg(2'h0, 16'h4321);
        #1 chk({web_port, serial_baud[15:0]}, 32'hBCDE4321);
        chk(register_pkt_en, 32'h1);
        tick(1);
        factory_restore_n <= 1'b0;
        tick(3);
        factory_restore_n <= 1'b1;
        tick(2);
        #1 chk(local_port, `SNBPC_DEF_LOCAL_PORT);
        chk(web_port, `SNBPC_DEF_WEB_PORT);
        chk(serial_baud, `SNBPC_DEF_BAUD);
        chk(register_pkt_en, 32'h0);
        $display("test restore done");
    endtask
    task test_accept;
        tick(1);
        client_connect_req <= 1'b1;
        listen_port_match <= `SNBPC_DEF_LOCAL_PORT;
        client_count <= 3'h5;
        tick(1);
        #1 chk(accept_client, 32'h1);
        tick(1);
        client_count <= 3'h6;
        tick(1);
        #1 chk(accept_client, 32'h0);
        tick(1);
        client_count <= 3'h2;
        listen_port_match <= 16'h0001;
        tick(1);
        #1 chk(accept_client, 32'h0);
        tick(1);
        client_connect_req <= 1'b0;
        upgrade_select <= 1'b1;
        tick(1);
        #1 chk({main_port_upgrade, debug_port_only}, 32'h3);
        tick(1);
        upgrade_select <= 1'b0;
        $display("test accept done");
    endtask
    task test_fanout_dns;
        tick(1);
        client_count <= 3'h6;
        serial_block_valid <= 1'b1;
        tick(1);
        serial_block_valid <= 1'b0;
        #1 chk(client_forward_mask, 32'h3F);
        tick(1);
        client_count <= 3'h3;
        serial_block_valid <= 1'b1;
        #1 chk(client_forward_mask, 32'h00);
        tick(1);
        serial_block_valid <= 1'b0;
        #1 chk(client_forward_mask, 32'h07);
        tick(1);
        dhcp_enable <= 1'b1;
        dhcp_dns <= 32'h0A000001;
        cfg(2'h0, 16'h0100);
        #1 chk(dns_server, 32'h0A000001);
        chk(dns_read_only, 32'h1);
        $display("test fanout and dns done");
    endtask
    initial begin
        test_defaults;
        test_send;
        test_run;
        test_receive;
        test_link;
        test_restore;
        test_accept;
        test_fanout_dns;
        report_and_stop;
    end
endmodule
